// ==== ddr3_cmd_decode.sv ====
// Command decoder and bank-timing guard of the memory device.
`timescale 1ns/1ps
`default_nettype none
module ddr3_cmd_decode #(
	parameter int ADDR_W = 14,
	parameter int BANKS = 8
) (
	input wire logic core_clk, // Command sampling clock.
	input wire logic rst, // Synchronous reset, high.
	input wire logic clk_en, // Freezes all state while low.
	input wire logic reset_pin_n, // Device reset pin, low active.
	input wire logic cke_pin, // Clock enable pin.
	input wire logic cs_n_pin, // Chip select, low active.
	input wire logic ras_n_pin, // Row strobe, low active.
	input wire logic cas_n_pin, // Column strobe, low active.
	input wire logic we_n_pin, // Write enable, low active.
	input wire logic [2:0] ba_pin, // Bank address.
	input wire logic [ADDR_W-1:0] addr_pin, // Address lines.
	input wire logic odt_pin, // Termination request.
	input wire logic otf_mode, // High when burst length chosen per command.
	output logic [3:0] cmd, // Accepted command code.
	output logic cmd_valid, // One-cycle pulse per accepted command.
	output logic [2:0] cmd_bank, // Target bank or mode register.
	output logic [ADDR_W-1:0] cmd_addr, // Address or operation code.
	output logic burst_chop, // Accepted access is a chop of four.
	output logic auto_pre, // Precharge-all, auto precharge or long calibration.
	output logic burst_busy, // Data burst in progress.
	output logic read_data_due, // Pulse when first read data is due.
	output logic [1:0] power_state, // Active, power-down or self-refresh.
	output logic refresh_run, // Refresh engine allowed to run.
	output logic odt_active, // Termination enabled.
	output logic [BANKS-1:0] bank_open, // Open banks.
	output logic cmd_reject // Pulse on an ignored command.
);
	localparam int CW = 8;
	// Bank select is three bits and the chop line is bit 12, so refuse less.
	if (BANKS != 8 || ADDR_W < 13) begin : g_bad_param
		$error("ddr3_cmd_decode needs eight banks and thirteen address bits");
	end

	// Pins come from the controller's domain, so two flops each.
	localparam int PW = 7 + 3 + ADDR_W;
	logic [PW-1:0] pin_s1;
	logic [PW-1:0] pin_s2;
	logic cke_prev;
	wire [PW-1:0] pin_raw = {reset_pin_n, cke_pin, cs_n_pin, ras_n_pin,
		cas_n_pin, we_n_pin, odt_pin, ba_pin, addr_pin};
	always_ff @(posedge core_clk) begin
		if (clk_en) begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			cke_prev <= pin_s2[PW-2];
		end
	end
	wire rstp_n = pin_s2[PW-1];
	wire cke = pin_s2[PW-2];
	wire cs_n = pin_s2[PW-3];
	wire [2:0] rcw = pin_s2[PW-4:PW-6];
	wire odt = pin_s2[PW-7];
	wire [2:0] ba = pin_s2[ADDR_W+2:ADDR_W];
	wire [ADDR_W-1:0] addr = pin_s2[ADDR_W-1:0];
	// The reset pin is sampled like the others; it acts as a reset term.
	wire kill = rst || !rstp_n;

	// Command table; undefined combinations fall to no command.
	function automatic ddr3_cmd_pkg::cmd_e decode(input logic cp,
		input logic cn, input logic csn, input logic [2:0] l);
		ddr3_cmd_pkg::cmd_e c;
		c = ddr3_cmd_pkg::CMD_NONE;
		if (cp && cn && !csn) begin
			case (l)
				3'h0: c = ddr3_cmd_pkg::CMD_MRS;
				3'h1: c = ddr3_cmd_pkg::CMD_REF;
				3'h2: c = ddr3_cmd_pkg::CMD_PRE;
				3'h3: c = ddr3_cmd_pkg::CMD_ACT;
				3'h4: c = ddr3_cmd_pkg::CMD_WR;
				3'h5: c = ddr3_cmd_pkg::CMD_RD;
				3'h6: c = ddr3_cmd_pkg::CMD_ZQ;
				default: c = ddr3_cmd_pkg::CMD_NONE;
			endcase
		end else if (cp && !cn) begin
			if (!csn && l == 3'h1) c = ddr3_cmd_pkg::CMD_SRE;
			else if (csn || l == 3'h7) c = ddr3_cmd_pkg::CMD_PDE;
		end else if (!cp && cn) begin
			if (csn || l == 3'h7) c = ddr3_cmd_pkg::CMD_PDX;
		end
		return c;
	endfunction
	// Termination level plays no part in the decode.
	wire ddr3_cmd_pkg::cmd_e raw_cmd = decode(cke_prev, cke, cs_n, rcw);

	logic [1:0] pstate;
	logic [CW-1:0] burst_cnt;
	logic [CW-1:0] rd_cnt;
	logic [CW-1:0] act_age [BANKS];
	logic [CW-1:0] pre_age [BANKS];
	wire is_sr = pstate == ddr3_cmd_pkg::ST_SELF_REFRESH;
	wire is_pd = pstate == ddr3_cmd_pkg::ST_POWER_DOWN;

	// Power-state moves. Exits follow a clock-enable rise only.
	wire ddr3_cmd_pkg::cmd_e state_cmd =
		(is_sr && cke && !cke_prev) ? ddr3_cmd_pkg::CMD_SRX :
		(is_pd && raw_cmd == ddr3_cmd_pkg::CMD_PDX) ? ddr3_cmd_pkg::CMD_PDX :
		(pstate == ddr3_cmd_pkg::ST_ACTIVE) ? raw_cmd : ddr3_cmd_pkg::CMD_NONE;
	wire all_idle = bank_open == '0 && burst_cnt == '0;
	wire [2:0] tb = ba;
	wire acc_cmd = state_cmd == ddr3_cmd_pkg::CMD_RD ||
		state_cmd == ddr3_cmd_pkg::CMD_WR;
	// Timing guard: accesses need an open bank past the activate delay.
	wire viol =
		(acc_cmd && (!bank_open[tb] || burst_busy ||
			act_age[tb] < CW'(ddr3_cmd_pkg::TRCD_CYC))) ||
		(state_cmd == ddr3_cmd_pkg::CMD_ACT && (bank_open[tb] ||
			act_age[tb] < CW'(ddr3_cmd_pkg::TRC_CYC) ||
			pre_age[tb] < CW'(ddr3_cmd_pkg::TRP_CYC))) ||
		(state_cmd == ddr3_cmd_pkg::CMD_SRE && !all_idle) ||
		((state_cmd == ddr3_cmd_pkg::CMD_REF ||
			state_cmd == ddr3_cmd_pkg::CMD_MRS) && !all_idle);
	wire take = state_cmd != ddr3_cmd_pkg::CMD_NONE && !viol;
	// Chop only when per-command mode is on and A12 is low.
	wire chop = acc_cmd && otf_mode && !addr[ddr3_cmd_pkg::A12_BIT];
	wire a10 = addr[ddr3_cmd_pkg::A10_BIT];
	wire [CW-1:0] blen = chop ? CW'(ddr3_cmd_pkg::BURST4_CYC) :
		CW'(ddr3_cmd_pkg::BURST8_CYC);
	wire ddr3_cmd_pkg::pstate_e next_pstate =
		!take ? ddr3_cmd_pkg::pstate_e'(pstate) :
		state_cmd == ddr3_cmd_pkg::CMD_SRE ? ddr3_cmd_pkg::ST_SELF_REFRESH :
		state_cmd == ddr3_cmd_pkg::CMD_PDE ? ddr3_cmd_pkg::ST_POWER_DOWN :
		(state_cmd == ddr3_cmd_pkg::CMD_SRX ||
			state_cmd == ddr3_cmd_pkg::CMD_PDX) ? ddr3_cmd_pkg::ST_ACTIVE :
		ddr3_cmd_pkg::pstate_e'(pstate);

	// Output register of the accepted command.
	always_ff @(posedge core_clk) begin
		if (kill) begin
			cmd <= 4'h0;
			cmd_valid <= 1'b0;
			cmd_bank <= ddr3_cmd_pkg::SLOT_MODE_RESET;
			cmd_addr <= '0;
			burst_chop <= 1'b0;
			auto_pre <= 1'b0;
			cmd_reject <= 1'b0;
			pstate <= ddr3_cmd_pkg::ST_ACTIVE;
		end else if (clk_en) begin
			cmd <= take ? state_cmd : 4'h0;
			cmd_valid <= take;
			cmd_bank <= ba;
			cmd_addr <= addr;
			burst_chop <= chop;
			auto_pre <= a10;
			cmd_reject <= state_cmd != ddr3_cmd_pkg::CMD_NONE && viol;
			pstate <= next_pstate;
		end
	end

	// Next burst count; busy is registered from it so the output is a flop.
	wire [CW-1:0] next_burst_cnt = (take && acc_cmd) ? blen :
		(burst_cnt != '0 ? burst_cnt - 1'b1 : burst_cnt);

	// Burst and read-latency counters; nothing can cut a burst short.
	always_ff @(posedge core_clk) begin
		if (kill) begin
			burst_cnt <= '0;
			burst_busy <= 1'b0;
			rd_cnt <= '0;
			read_data_due <= 1'b0;
		end else if (clk_en) begin
			burst_cnt <= next_burst_cnt;
			burst_busy <= next_burst_cnt != '0;
			if (take && state_cmd == ddr3_cmd_pkg::CMD_RD)
				rd_cnt <= CW'(ddr3_cmd_pkg::READ_ACCESS_CYC);
			else if (rd_cnt != '0) rd_cnt <= rd_cnt - 1'b1;
			read_data_due <= rd_cnt == CW'(1);
		end
	end

	// Per-bank open flag and cycle ages since activate and precharge.
	genvar b;
	for (b = 0; b < BANKS; b++) begin : g_bank
		wire hit = tb == 3'(b);
		wire pre_hit = take && ((state_cmd == ddr3_cmd_pkg::CMD_PRE &&
			(hit || a10)) || (acc_cmd && hit && a10));
		wire act_hit = take && state_cmd == ddr3_cmd_pkg::CMD_ACT && hit;
		always_ff @(posedge core_clk) begin
			if (kill) begin
				bank_open[b] <= 1'b0;
				act_age[b] <= '1;
				pre_age[b] <= '1;
			end else if (clk_en) begin
				if (act_hit) bank_open[b] <= 1'b1;
				else if (pre_hit) bank_open[b] <= 1'b0;
				act_age[b] <= act_hit ? '0 :
					(act_age[b] == '1 ? act_age[b] : act_age[b] + 1'b1);
				pre_age[b] <= pre_hit ? '0 :
					(pre_age[b] == '1 ? pre_age[b] : pre_age[b] + 1'b1);
			end
		end
	end

	// Status flags follow the power state.
	always_ff @(posedge core_clk) begin
		if (kill) begin
			power_state <= 2'h0;
			refresh_run <= 1'b0;
			odt_active <= 1'b0;
		end else if (clk_en) begin
			power_state <= next_pstate;
			refresh_run <= next_pstate == ddr3_cmd_pkg::ST_SELF_REFRESH;
			odt_active <= odt &&
				next_pstate != ddr3_cmd_pkg::ST_SELF_REFRESH;
		end
	end

	// Checks on the status flags, the burst counter and the decode.
	a_pd_no_ref: assert property (@(posedge core_clk) disable iff (kill)
		power_state == 2'h1 |-> !refresh_run)
		else $error("refresh during power-down");
	a_sr_no_odt: assert property (@(posedge core_clk) disable iff (kill)
		power_state == 2'h2 |-> !odt_active)
		else $error("termination in self-refresh");
	a_burst_len: assert property (@(posedge core_clk) disable iff (kill)
		clk_en && take && acc_cmd && !chop |=>
		burst_cnt == CW'(ddr3_cmd_pkg::BURST8_CYC))
		else $error("wrong burst length");
	a_burst_whole: assert property (@(posedge core_clk) disable iff (kill)
		clk_en && burst_busy && $past(burst_cnt) > burst_cnt |->
		!take || !acc_cmd)
		else $error("burst cut short");
	a_read_due: assert property (@(posedge core_clk)
		disable iff (kill || !clk_en)
		take && state_cmd == ddr3_cmd_pkg::CMD_RD |=> ##1 read_data_due)
		else $error("read data not due on time");
	a_reject_keep: assert property (@(posedge core_clk) disable iff (kill)
		clk_en && cmd_reject |-> !cmd_valid)
		else $error("rejected command accepted");
	a_srx_async: assert property (@(posedge core_clk) disable iff (kill)
		clk_en && is_sr && cke && !cke_prev |=> power_state == 2'h0)
		else $error("self-refresh exit missed");
	a_act_opens: assert property (@(posedge core_clk) disable iff (kill)
		clk_en && take && state_cmd == ddr3_cmd_pkg::CMD_ACT |=>
		bank_open[$past(ba)])
		else $error("activate did not open bank");
	a_cmd_decode: assert property (@(posedge core_clk) disable iff (kill)
		clk_en && take |=> cmd == $past(state_cmd))
		else $error("command code mismatch");
	a_nop_keeps: assert property (@(posedge core_clk) disable iff (kill)
		clk_en && cke_prev && cke && (cs_n || rcw == 3'h7) && !is_sr |=>
		!cmd_valid)
		else $error("deselect acted");
endmodule // ddr3_cmd_decode
`default_nettype wire

// ==== ddr3_cmd_pkg.sv ====
// Constants and types shared by the command decoder.
package ddr3_cmd_pkg;
	localparam int CLK_PERIOD_PS = 40000;
	localparam int READ_ACCESS_PS = 13750;
	localparam int READ_ACCESS_CYC =
		(READ_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TRCD_PS = 13750;
	localparam int TRCD_CYC = (TRCD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TRP_PS = 13750;
	localparam int TRP_CYC = (TRP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TRC_PS = 48750;
	localparam int TRC_CYC = (TRC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TRAS_PS = 35000;
	localparam int TRAS_CYC = (TRAS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int BURST8_CYC = 4;
	localparam int BURST4_CYC = 2;
	localparam int A10_BIT = 10;
	localparam int A12_BIT = 12;
	localparam logic [2:0] SLOT_MODE_RESET = 3'h0;
	typedef enum logic [3:0] {
		CMD_NONE = 4'h0,
		CMD_MRS = 4'h1,
		CMD_REF = 4'h2,
		CMD_PRE = 4'h3,
		CMD_ACT = 4'h4,
		CMD_WR = 4'h5,
		CMD_RD = 4'h6,
		CMD_ZQ = 4'h7,
		CMD_SRE = 4'h8,
		CMD_SRX = 4'h9,
		CMD_PDE = 4'ha,
		CMD_PDX = 4'hb
	} cmd_e;
	typedef enum logic [1:0] {
		ST_ACTIVE = 2'b00,
		ST_POWER_DOWN = 2'b01,
		ST_SELF_REFRESH = 2'b10
	} pstate_e;
endpackage

// ==== ddr3_ctrl_model.sv ====
// Pin-level memory controller model that drives the command lines.
`timescale 1ns/1ps
`default_nettype none
module ddr3_ctrl_model (
	input wire logic core_clk, // Command clock.
	output logic reset_pin_n, // Device reset, low active.
	output logic cke_pin, // Clock enable.
	output logic [3:0] cmd_pins, // Select, row, column, write strobes.
	output logic [2:0] ba_pin, // Bank address.
	output logic [13:0] addr_pin // Address lines.
);
	// Reset stays released and the bus idles on deselect from time zero.
	initial begin
		reset_pin_n = 1'b1;
		cke_pin = 1'b1;
		cmd_pins = 4'hf;
		ba_pin = 3'h0;
		addr_pin = 14'h0;
	end
	// One command for one cycle, then a no-operation; unused lines flip so
	// that a decoder reading stale address bits cannot pass by luck.
	task automatic send(input logic [3:0] c, input logic [2:0] b,
		input logic [13:0] a, input logic k);
		@(negedge core_clk);
		cmd_pins = c;
		ba_pin = b;
		addr_pin = a;
		cke_pin = k;
		@(negedge core_clk);
		cmd_pins = 4'h7;
		ba_pin = ~b;
		addr_pin = ~a;
	endtask
endmodule // ddr3_ctrl_model
`default_nettype wire

// ==== ddr3_command_decode_timing_tb.sv ====
// Self-checking bench for the command decoder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
	$display("Error at %0t: got %h expected %h", $time, a, b); end end
module ddr3_command_decode_timing_tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic odt_pin = 1'b0;
	logic otf_mode = 1'b1;
	logic clk_en = 1'b1;
	logic reset_pin_n, cke_pin;
	logic [3:0] cp;
	logic [2:0] ba_pin;
	logic [13:0] addr_pin;
	logic [3:0] cmd;
	logic cmd_valid, burst_chop, auto_pre, burst_busy, read_data_due;
	logic [2:0] cmd_bank;
	logic [13:0] cmd_addr;
	logic [1:0] power_state;
	logic refresh_run, odt_active, cmd_reject;
	logic [7:0] bank_open;
	int failures = 0;
	int compares = 0;
	always #20 core_clk = ~core_clk;
	ddr3_ctrl_model u_ctrl (.core_clk(core_clk), .reset_pin_n(reset_pin_n),
		.cke_pin(cke_pin), .cmd_pins(cp), .ba_pin(ba_pin), .addr_pin(addr_pin));
	ddr3_cmd_decode u_dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
		.reset_pin_n(reset_pin_n), .cke_pin(cke_pin), .cs_n_pin(cp[3]),
		.ras_n_pin(cp[2]), .cas_n_pin(cp[1]), .we_n_pin(cp[0]),
		.ba_pin(ba_pin), .addr_pin(addr_pin), .odt_pin(odt_pin),
		.otf_mode(otf_mode), .cmd(cmd), .cmd_valid(cmd_valid),
		.cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .burst_chop(burst_chop),
		.auto_pre(auto_pre), .burst_busy(burst_busy),
		.read_data_due(read_data_due), .power_state(power_state),
		.refresh_run(refresh_run), .odt_active(odt_active),
		.bank_open(bank_open), .cmd_reject(cmd_reject));
	// Prints the counts and the verdict, then stops the run.
	task automatic end_sim();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Sends a command and waits, bounded, for an accept or a reject pulse.
	task automatic issue(input logic [3:0] c, input logic [2:0] b,
		input logic [13:0] a, input logic k, input logic rej);
		logic seen;
		seen = 1'b0;
		u_ctrl.send(c, b, a, k);
		for (int i = 0; i < 8 && !seen; i++) begin
			@(posedge core_clk);
			#1 seen = (cmd_valid === 1'b1) || (cmd_reject === 1'b1);
		end
		if (!seen) begin
			failures++;
			end_sim();
		end
		`CHK(cmd_reject, rej)
	endtask
	// Waits a bounded time for a power state; a timeout ends the run.
	task automatic wait_ps(input logic [1:0] s);
		for (int i = 0; i < 10 && power_state !== s; i++) begin
			@(posedge core_clk);
			#1;
		end
		`CHK(power_state, s)
		if (power_state !== s) end_sim();
	endtask
	// Mode register set and long calibration decode with their fields.
	// The mode word keeps its latency field at the slowest supported code.
	task automatic t_mode();
		issue(4'h0, 3'h2, 14'h0203, 1'b1, 1'b0);
		`CHK(cmd, ddr3_cmd_pkg::CMD_MRS)
		`CHK({cmd_bank, cmd_addr}, {3'h2, 14'h0203})
		issue(4'h6, 3'h0, 14'h0400, 1'b1, 1'b0);
		`CHK({cmd, auto_pre}, {ddr3_cmd_pkg::CMD_ZQ, 1'b1})
	endtask
	// Deselect carries command-like strobes so an ignored select would show.
	// Each window spans the edges at which that command reaches the outputs.
	task automatic t_idle();
		u_ctrl.send(4'h8, 3'h5, 14'h1fff, 1'b1);
		for (int i = 0; i < 5; i++) begin
			@(posedge core_clk);
			#1 `CHK(cmd_valid | cmd_reject, 1'b0)
		end
		u_ctrl.send(4'h7, 3'h1, 14'h0000, 1'b1);
		for (int i = 0; i < 5; i++) begin
			@(posedge core_clk);
			#1 `CHK(cmd_valid | cmd_reject, 1'b0)
		end
	endtask
	// Power-down, then self-refresh with termination requested.
	task automatic t_power();
		@(negedge core_clk) odt_pin = 1'b1;
		u_ctrl.send(4'h7, 3'h0, 14'h0, 1'b0);
		wait_ps(2'h1);
		`CHK({refresh_run, odt_active}, 2'b01)
		u_ctrl.send(4'h7, 3'h0, 14'h0, 1'b1);
		wait_ps(2'h0);
		// All banks are closed here, so entry is legal.
		u_ctrl.send(4'h1, 3'h0, 14'h0, 1'b0);
		wait_ps(2'h2);
		`CHK({refresh_run, odt_active}, 2'b10)
		u_ctrl.send(4'hf, 3'h0, 14'h0, 1'b1);
		wait_ps(2'h0);
		// No write may follow the exit for 512 cycles.
		repeat (512) @(posedge core_clk);
		@(negedge core_clk) odt_pin = 1'b0;
	endtask
	// Open a bank, read a chop of four with auto precharge, count the burst.
	task automatic t_read();
		int n;
		logic due;
		issue(4'h3, 3'h3, 14'h0abc, 1'b1, 1'b0);
		`CHK(bank_open[3], 1'b1)
		// The accept wait keeps the activate well ahead of the access.
		issue(4'h5, 3'h3, 14'h0408, 1'b1, 1'b0);
		`CHK({cmd, burst_chop, auto_pre}, {ddr3_cmd_pkg::CMD_RD, 2'b11})
		n = 0;
		due = 1'b0;
		for (int i = 0; i < 12 && burst_busy === 1'b1; i++) begin
			n++;
			@(posedge core_clk);
			#1 due = due | (i == 0 && read_data_due === 1'b1);
		end
		`CHK(n, ddr3_cmd_pkg::BURST4_CYC)
		`CHK(due, 1'b1)
	endtask
	// Fixed mode ignores the chop line; a closed bank refuses access.
	task automatic t_fixed();
		@(negedge core_clk) otf_mode = 1'b0;
		issue(4'h3, 3'h1, 14'h0010, 1'b1, 1'b0);
		issue(4'h4, 3'h1, 14'h0000, 1'b1, 1'b0);
		`CHK({cmd, burst_chop}, {ddr3_cmd_pkg::CMD_WR, 1'b0})
		issue(4'h5, 3'h6, 14'h0000, 1'b1, 1'b1);
		`CHK(cmd_valid, 1'b0)
	endtask
	// A low clock enable freezes the block, so an activate sent then is lost.
	task automatic t_freeze();
		@(negedge core_clk) clk_en = 1'b0;
		u_ctrl.send(4'h3, 3'h0, 14'h0000, 1'b1);
		clk_en = 1'b1;
		for (int i = 0; i < 5; i++) begin
			@(posedge core_clk);
			#1 `CHK({cmd_valid, bank_open[0]}, 2'b00)
		end
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		@(negedge core_clk) rst = 1'b0;
		t_mode();
		t_idle();
		t_freeze();
		t_power();
		t_read();
		t_fixed();
		end_sim();
	end
endmodule // ddr3_command_decode_timing_tb
`default_nettype wire
